// ### rtl/sdil_pkg.sv
// Overview of operation
// RULE_01: shift enable low, latch enable high: shift one bit
// RULE_02: input register and output latch are separate
// RULE_03: latch enable low, input enable high: transfer
// RULE_04: both enables low: shift and load together
// RULE_05: stages pass while enable low, hold when high
// RULE_06: all control inputs are active low
// RULE_07: clear low zeroes both stages at once
// RULE_08: word travels most significant bit first
// RULE_09: code is straight binary, zero is zero output
// RULE_10: clock period 100 ns, phases 50 ns minimum
// RULE_11: clear held low at least 200 ns
// RULE_12: both enables high or clock idle: hold
// RULE_13: input register top bit drives serial output
// RULE_14: cascade needs sixteen clocks per device
package sdil_pkg;
	localparam int          WORD_BITS     = 16;
	localparam logic [15:0] CODE_ZERO     = 16'h0000;
	localparam logic [15:0] CODE_HALF     = 16'h8000;
	localparam logic [15:0] CODE_FULL     = 16'hFFFF;
	localparam int          CLK_MHZ       = 10;
	localparam int          SCLK_LOW_NS   = 50;
	localparam int          SCLK_HIGH_NS  = 50;
	localparam int          CLEAR_NS      = 200;
	localparam int          SCLK_LOW_CYC  = (SCLK_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int          SCLK_HIGH_CYC = (SCLK_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int          CLEAR_CYC     = (CLEAR_NS * CLK_MHZ + 999) / 1000;
	// idle level of the active-low link pins, so no false edge follows reset
	localparam logic [1:0]  SYNC_IDLE     = 2'h3;
endpackage

// ### rtl/sdil_if.sv
`timescale 1ns/1ps
interface sdil_if;
	logic serial_clk;
	logic input_reg_enable_n;
	logic output_latch_enable_n;
	logic async_zero_n;
	logic serial_in;
	logic serial_out;
	modport host (output serial_clk, output input_reg_enable_n, output output_latch_enable_n,
		output async_zero_n, output serial_in, input serial_out);
	modport dev (input serial_clk, input input_reg_enable_n, input output_latch_enable_n,
		input async_zero_n, input serial_in, output serial_out);
endinterface

// ### rtl/sdil_device.sv
`timescale 1ns/1ps
module sdil_device (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic         clk_en,
	sdil_if.dev               link,
	output logic [15:0]       dac_code
);
	typedef struct packed {
		logic [1:0]  sync_clk;
		logic [1:0]  sync_ie;
		logic [1:0]  sync_oe;
		logic [1:0]  sync_din;
		logic [1:0]  sync_zero;
		logic        clk_prev;
		logic [15:0] input_reg;
		logic [15:0] out_latch; // second stage, loaded only on transfer or zeroed by clear, see RULE_02
		logic        sout;
	} sdil_dev_state_t;

	sdil_dev_state_t st;
	sdil_dev_state_t next_st;
	logic            rise;
	logic [15:0]     shifted;

	assign link.serial_out = st.sout;
	assign dac_code        = st.out_latch; // see RULE_09

	always_comb begin
		next_st          = st;
		next_st.sync_clk = {st.sync_clk[0], link.serial_clk};
		next_st.sync_ie  = {st.sync_ie[0], link.input_reg_enable_n};
		next_st.sync_oe  = {st.sync_oe[0], link.output_latch_enable_n};
		next_st.sync_din = {st.sync_din[0], link.serial_in};
		next_st.sync_zero = {st.sync_zero[0], link.async_zero_n};
		next_st.clk_prev = st.sync_clk[1];
		rise    = st.sync_clk[1] && !st.clk_prev; // completes high-low-high pulse, see RULE_12
		shifted = {st.input_reg[14:0], st.sync_din[1]}; // first bit ends on top, see RULE_08
		if (!st.sync_zero[1]) begin // all controls active low, see RULE_06
			next_st.input_reg = sdil_pkg::CODE_ZERO; // see RULE_07
			next_st.out_latch = sdil_pkg::CODE_ZERO;
		end else if (rise) begin
			if (!st.sync_ie[1]) begin
				next_st.input_reg = shifted; // see RULE_01
			end
			if (!st.sync_oe[1]) begin
				// both low: new word flows through, see RULE_04
				next_st.out_latch = st.sync_ie[1] ? st.input_reg : shifted; // see RULE_03
			end
		end
		next_st.sout = next_st.input_reg[sdil_pkg::WORD_BITS-1]; // see RULE_13
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st           <= '0;
			st.sync_clk  <= sdil_pkg::SYNC_IDLE;
			st.sync_ie   <= sdil_pkg::SYNC_IDLE;
			st.sync_oe   <= sdil_pkg::SYNC_IDLE;
			st.sync_zero <= sdil_pkg::SYNC_IDLE;
			st.clk_prev  <= 1'b1;
		end else if (clk_en) begin
			st <= next_st; // see RULE_05
		end
	end
endmodule

// ### rtl/sdil_host.sv
`timescale 1ns/1ps
module sdil_host #(
	parameter int CHAIN = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic         clk_en,
	sdil_if.host              link,
	input  wire logic         send,
	input  wire logic [15:0]  word,
	input  wire logic         load,
	input  wire logic         clear,
	output logic              busy,
	output logic              echo
);
	typedef enum logic [1:0] {IDLE = 2'h0, HIGH = 2'h1, LOW = 2'h3, ZERO_PULSE = 2'h2} sdil_hst_t;
	typedef struct packed {
		sdil_hst_t   fsm;
		logic [15:0] shreg;
		logic [15:0] bits;
		logic [3:0]  cnt;
		logic        sclk;
		logic        ie_n;
		logic        oe_n;
		logic        zero_n;
		logic        din;
		logic        busy;
		logic [1:0]  sync_echo;
	} sdil_host_state_t;

	sdil_host_state_t st;
	sdil_host_state_t next_st;

	assign link.serial_clk            = st.sclk;
	assign link.input_reg_enable_n    = st.ie_n; // see RULE_06
	assign link.output_latch_enable_n = st.oe_n;
	assign link.async_zero_n          = st.zero_n;
	assign link.serial_in             = st.din;
	assign busy                       = st.busy;
	assign echo                       = st.sync_echo[1];

	always_comb begin
		next_st           = st;
		next_st.sync_echo = {st.sync_echo[0], link.serial_out};
		case (st.fsm)
			IDLE: begin
				next_st.busy = 1'b0;
				if (clear) begin
					next_st.zero_n = 1'b0;
					next_st.cnt    = 4'(sdil_pkg::CLEAR_CYC); // see RULE_11
					next_st.busy   = 1'b1;
					next_st.fsm    = ZERO_PULSE;
				end else if (send || load) begin
					next_st.shreg   = word;
					next_st.bits    = send ? 16'(sdil_pkg::WORD_BITS * CHAIN) : 16'h0001; // see RULE_14
					// send and load together run both stages at once
					next_st.ie_n    = !send;
					next_st.oe_n    = !load; // see RULE_04
					next_st.din     = word[15]; // see RULE_08
					next_st.cnt     = 4'(sdil_pkg::SCLK_HIGH_CYC);
					next_st.busy    = 1'b1;
					next_st.fsm     = HIGH;
				end
			end
			HIGH: begin
				if (st.cnt > 4'h1) begin
					next_st.cnt = st.cnt - 4'h1;
				end else if (st.bits == 16'h0000) begin
					next_st.ie_n = 1'b1;
					next_st.oe_n = 1'b1;
					next_st.fsm  = IDLE;
				end else begin
					next_st.sclk = 1'b0;
					// data moves on the fall so it is settled across the rise
					next_st.din  = st.shreg[15];
					next_st.cnt  = 4'(sdil_pkg::SCLK_LOW_CYC); // see RULE_10
					next_st.fsm  = LOW;
				end
			end
			LOW: begin
				if (st.cnt > 4'h1) begin
					next_st.cnt = st.cnt - 4'h1;
				end else begin
					next_st.sclk  = 1'b1; // see RULE_01
					next_st.bits  = st.bits - 16'h0001;
					next_st.shreg = {st.shreg[14:0], 1'b0};
					next_st.cnt   = 4'(sdil_pkg::SCLK_HIGH_CYC);
					next_st.fsm   = HIGH;
				end
			end
			ZERO_PULSE: begin
				if (st.cnt > 4'h1) begin
					next_st.cnt = st.cnt - 4'h1;
				end else begin
					next_st.zero_n = 1'b1;
					next_st.fsm   = IDLE;
				end
			end
			default: next_st.fsm = IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st       <= '0;
			st.sclk  <= 1'b1;
			st.ie_n  <= 1'b1;
			st.oe_n  <= 1'b1;
			st.zero_n <= 1'b1;
		end else if (clk_en) begin
			st <= next_st;
		end
	end
endmodule

// ### test/sdil_monitor.sv
`timescale 1ns/1ps
module sdil_monitor (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic serial_clk,
	input wire logic input_reg_enable_n,
	input wire logic output_latch_enable_n,
	input wire logic async_zero_n,
	input wire logic serial_in,
	input wire logic serial_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_clear_zeroes: assert property (!async_zero_n [*4] |-> !serial_out)
		else $error("serial out not cleared");
	a_hold_no_enable: assert property ((input_reg_enable_n && async_zero_n) [*8] |-> $stable(serial_out))
		else $error("serial out moved while idle");
	a_clk_idle_high: assert property (input_reg_enable_n && output_latch_enable_n |-> serial_clk)
		else $error("strobe without enable");
	a_low_bounded: assert property ($fell(serial_clk) |=> !serial_clk ##[1:4] serial_clk)
		else $error("bad low phase");
	a_clear_width: assert property ($fell(async_zero_n) |=> !async_zero_n [*3] ##[1:6] async_zero_n)
		else $error("bad clear width");
	a_rise_enables: assert property ($rose(serial_clk) |-> $stable({input_reg_enable_n, output_latch_enable_n}))
		else $error("enable moved at strobe");
	a_low_stable: assert property ((!serial_clk && !$past(serial_clk)) || $rose(serial_clk)
		|-> $stable({input_reg_enable_n, output_latch_enable_n, serial_in}))
		else $error("input moved in low phase");
	a_clear_idle: assert property (!async_zero_n |-> serial_clk && input_reg_enable_n && output_latch_enable_n)
		else $error("clear not from idle");
endmodule

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic        ref_clk, rst_n, host_en, dev_en, send, load, clear, busy, echo;
	logic [15:0] word, dac_code, prev;
	int          errors, compares;
	logic [15:0] rows [4] = '{sdil_pkg::CODE_HALF, sdil_pkg::CODE_FULL, 16'h0001, 16'hA5C3};
	sdil_if link();
	sdil_host sdil_host_inst (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(host_en), .link(link), .send(send),
		.word(word), .load(load), .clear(clear), .busy(busy), .echo(echo));
	sdil_device sdil_device_inst (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(dev_en), .link(link), .dac_code(dac_code));
	sdil_monitor sdil_monitor_inst (.ref_clk(ref_clk), .rst_n(rst_n), .serial_clk(link.serial_clk),
		.input_reg_enable_n(link.input_reg_enable_n), .output_latch_enable_n(link.output_latch_enable_n),
		.async_zero_n(link.async_zero_n), .serial_in(link.serial_in), .serial_out(link.serial_out));
	initial begin
		ref_clk = 0;
		forever #50 ref_clk = ~ref_clk;
	end
	// host runs at half rate so the device sees two-cycle strobe phases
	always @(posedge ref_clk) #1 host_en = ~host_en;
	task print_verdict;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic req(input logic s, input logic l, input logic c);
		int n;
		n = 0;
		@(posedge ref_clk) #1 {send, load, clear} = {s, l, c};
		while (busy !== 1'b1 && n < 400) begin
			@(posedge ref_clk) #1 n++;
		end
		{send, load, clear} = 3'b000;
		while (busy !== 1'b0 && n < 400) begin
			@(posedge ref_clk) #1 n++;
		end
		if (n >= 400) begin
			errors++;
			$display("CHECK FAILED %0t timeout", $time);
		end
		repeat (8) @(posedge ref_clk);
		#1;
	endtask
	initial begin
		rst_n    = 0;
		host_en  = 0;
		dev_en   = 1;
		send     = 0;
		load     = 0;
		clear    = 0;
		word     = 16'h0000;
		prev     = 16'h0000;
		errors   = 0;
		compares = 0;
		repeat (6) @(posedge ref_clk);
		#1 rst_n = 1;
		check(dac_code, sdil_pkg::CODE_ZERO);
		foreach (rows[i]) begin
			word = rows[i];
			req(1'b1, 1'b0, 1'b0);
			check(dac_code, prev);
			check({15'h0000, echo}, {15'h0000, rows[i][15]});
			req(1'b0, 1'b1, 1'b0);
			check(dac_code, rows[i]);
			prev = rows[i];
			$display("row %0d done", i);
		end
		word = 16'h3C5A;
		req(1'b1, 1'b1, 1'b0);
		check(dac_code, 16'h3C5A);
		check({15'h0000, echo}, 16'h0000);
		$display("two-wire test done");
		// a device frozen by its clock enable misses the whole word
		dev_en = 0;
		word   = 16'hFFFF;
		req(1'b1, 1'b1, 1'b0);
		dev_en = 1;
		repeat (8) @(posedge ref_clk);
		#1;
		check(dac_code, 16'h3C5A);
		check({15'h0000, echo}, 16'h0000);
		$display("freeze test done");
		req(1'b0, 1'b0, 1'b1);
		check(dac_code, sdil_pkg::CODE_ZERO);
		check({15'h0000, echo}, 16'h0000);
		$display("clear test done");
		word = 16'h8001;
		req(1'b1, 1'b0, 1'b0);
		req(1'b0, 1'b1, 1'b0);
		check(dac_code, 16'h8001);
		rst_n = 0;
		repeat (2) @(posedge ref_clk);
		#1 rst_n = 1;
		check(dac_code, sdil_pkg::CODE_ZERO);
		check({15'h0000, echo}, 16'h0000);
		word = sdil_pkg::CODE_HALF;
		req(1'b1, 1'b0, 1'b0);
		req(1'b0, 1'b1, 1'b0);
		check(dac_code, sdil_pkg::CODE_HALF);
		$display("reset test done");
		print_verdict;
	end
endmodule
